// ### design/udt_core.sv
// One channel of a 16-bit up/down timer with two compare circuits.
//
// Contract
// - 16-bit counter advances on each rising count clock edge: up, down or up/down.
// - Direction field plus single-cycle bit give six counting modes.
// - Software limit bounds the counter to 0x0000 through the limit.
// - Preset clears to 0x0000, or loads the limit in down mode.
// - Counting up, counter clears to 0x0000 on the count after the limit.
// - Run bit starts counting; stopping depends on repeat or single-cycle.
// - Live count readable; software reads twice or stops the counter first.
// - Running status reads 1 while counting, 0 when idle.
// - Direction status reads 1 counting up, 0 counting down.
// - Repeat up wraps to 0x0000 and runs until run is cleared.
// - Counting up, new limit above count is the target; below clears count.
// - Single-cycle up wraps to 0x0000 past the limit, then stops.
// - Repeat down reloads limit on underflow; new limit waits for underflow.
// - Single-cycle down reloads limit on underflow, then stops.
// - Repeat up/down runs 0x0000 to limit and back until run is cleared.
// - Up/down: limit change while descending applies to the next ascent.
// - Single-cycle up/down stops on reaching 0x0000 while descending.
// - Each compare circuit has its own mode bit: 0 compare, 1 capture; no capture logic, so 1 turns compare off; 1 on both also stops limit and zero flags.
// - Compare mode: count equals buffer asserts match and sets event flag.
// - Limit and zero set their flags while either circuit is in compare mode; writing 1 clears any flag.
// - Comparator uses a buffered compare value loaded at a chosen moment.
// - Interrupt request only for a set flag whose enable bit is 1.
// - Busy reads 1 while a new limit transfers; limit writes then ignored.
//
// The placing of the registers and strobed register access were left to the implementer.
`include "udt_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module udt_core
    import udt_pkg::*;
(
    input  wire logic                   MCLK,
    input  wire logic                   RESET_N,
    input  wire logic                   COUNT_CLOCK,
    input  wire logic [`UDT_ADDR_W-1:0] ADDR,
    input  wire logic [15:0]            WDATA,
    input  wire logic                   WR_STB,
    input  wire logic                   RD_STB,
    output logic      [15:0]            RDATA,
    output logic                        IRQ,
    output logic      [1:0]             CC_MATCH
);

    // ======================================================================
    // Reset release
    // ======================================================================
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ======================================================================
    // State
    // ======================================================================
    logic        enable_q,    enable_d;
    logic        run_q,       run_d;
    logic        oneshot_q,   oneshot_d;
    udt_dir_t    dir_sel_q,   dir_sel_d;
    logic [15:0] limit_q,     limit_d;
    logic [15:0] limit_act_q, limit_act_d;
    logic        lbusy_q,     lbusy_d;
    logic [15:0] count_q,     count_d;
    logic        phase_up_q,  phase_up_d;
    logic [5:0]  flags_q,     flags_d;
    logic [5:0]  enables_q,   enables_d;
    logic [1:0]  cc_mode_q,   cc_mode_d;
    udt_buf_t    cc_buf_q [2];
    udt_buf_t    cc_buf_d [2];
    logic [15:0] cc_val_q [2];
    logic [15:0] cc_val_d [2];
    logic [15:0] cc_cmp_q [2];
    logic [15:0] cc_cmp_d [2];
    logic        cclk_q,      cclk_d;
    logic [15:0] rdata_d;
    logic        irq_d;
    logic [1:0]  match_d;

    logic        wr_ctl;
    logic        tick;
    logic        running;
    logic        up_now;
    logic        hit_zero;
    logic        hit_limit;
    logic        stop_now;
    logic        any_compare;

    // Flag word as it sits in the event registers.
    function automatic logic [15:0] ev_word(input logic [5:0] f);
        ev_word = {10'h000, f[5:4], 2'h0, f[1:0]};
    endfunction

    function automatic logic [5:0] ev_bits(input logic [15:0] w);
        ev_bits = {w[`UDT_EV_ZERO], w[`UDT_EV_LIMIT], 2'h0, w[`UDT_EV_CC1], w[`UDT_EV_CC0]};
    endfunction

    // Whether a circuit's compare buffer takes the written value now.
    function automatic logic buf_load(input udt_buf_t sel, input logic z, input logic m,
                                      input logic stopped);
        unique case (sel)
            UDT_BUF_AT_ZERO:  buf_load = z;
            UDT_BUF_AT_LIMIT: buf_load = m;
            UDT_BUF_AT_BOTH:  buf_load = z | m;
            UDT_BUF_AT_STOP:  buf_load = stopped;
            default:          buf_load = 1'b1;
        endcase
    endfunction

    // ======================================================================
    // Counter
    // ======================================================================
    // The count clock is sampled in the bus clock, so it must run at less
    // than half the bus clock rate; each of its rising edges is one count.
    assign tick    = COUNT_CLOCK & ~cclk_q;
    assign running = run_q & enable_q;
    assign wr_ctl  = WR_STB && (ADDR == `UDT_REG_CONTROL);
    assign up_now  = (dir_sel_q == UDT_DIR_DOWN) ? 1'b0 :
                     (dir_sel_q == UDT_DIR_UPDOWN) ? phase_up_q : 1'b1;

    always_comb begin
        cclk_d      = COUNT_CLOCK;
        count_d     = count_q;
        phase_up_d  = phase_up_q;
        limit_act_d = limit_act_q;
        lbusy_d     = lbusy_q;
        run_d       = run_q;
        stop_now    = 1'b0;
        // A new limit waits in the holding register until the next count edge (descending in up/down: the turn at 0x0000), or one cycle while stopped.
        if (lbusy_q && (tick || !running)) begin
            lbusy_d = 1'b0;
            if (dir_sel_q == UDT_DIR_UP || phase_up_q || !running) begin
                limit_act_d = limit_q;
            end
        end
        if (running && tick) begin
            unique case (dir_sel_q)
                UDT_DIR_DOWN: begin
                    if (count_q == `UDT_RST_ZERO16) begin
                        // Down counting picks up a changed limit only here.
                        count_d     = limit_q;
                        limit_act_d = limit_q;
                        stop_now    = oneshot_q;
                    end else begin
                        count_d = count_q - 16'h0001;
                    end
                end
                UDT_DIR_UPDOWN: begin
                    if (phase_up_q) begin
                        // A limit handed over at this edge already bounds this count.
                        if (count_q > limit_act_d) begin
                            count_d = `UDT_RST_ZERO16;
                        end else if (count_q == limit_act_d) begin
                            count_d    = count_q - 16'h0001;
                            phase_up_d = 1'b0;
                            if (count_q == `UDT_RST_ZERO16) begin
                                count_d    = `UDT_RST_ZERO16;
                                phase_up_d = 1'b1;
                                stop_now   = oneshot_q;
                            end
                        end else begin
                            count_d = count_q + 16'h0001;
                        end
                    end else begin
                        if (count_q == `UDT_RST_ZERO16) begin
                            count_d    = 16'h0001;
                            phase_up_d = 1'b1;
                            // A limit written during the descent waits for this turn.
                            // Taking it earlier would cut the descent short.
                            limit_act_d = limit_q;
                        end else begin
                            count_d = count_q - 16'h0001;
                            if (count_q == 16'h0001) begin
                                stop_now   = oneshot_q;
                                phase_up_d = oneshot_q;
                            end
                        end
                    end
                end
                default: begin
                    // The old limit here would wrap early or overshoot a lowered one.
                    if (count_q >= limit_act_d) begin
                        count_d  = `UDT_RST_ZERO16;
                        stop_now = oneshot_q;
                    end else begin
                        count_d = count_q + 16'h0001;
                    end
                end
            endcase
            if (stop_now) begin
                run_d = 1'b0;
            end
        end
        if (wr_ctl) begin
            run_d = WDATA[`UDT_CTL_RUN];
            if (WDATA[`UDT_CTL_PRESET]) begin
                phase_up_d = 1'b1;
                if (udt_dir_t'(WDATA[`UDT_CTL_DIR_HI:`UDT_CTL_DIR_LO]) == UDT_DIR_DOWN) begin
                    count_d = limit_q;
                end else begin
                    count_d = `UDT_RST_ZERO16;
                end
                limit_act_d = limit_q;
            end
        end
        if (WR_STB && (ADDR == `UDT_REG_LIMIT) && !lbusy_q) begin
            lbusy_d = 1'b1;
        end
    end

    assign hit_zero  = running && tick && (count_d == `UDT_RST_ZERO16) &&
                       (count_q != `UDT_RST_ZERO16 || dir_sel_q != UDT_DIR_UP);
    assign hit_limit = running && tick && (count_d == limit_act_d);

    // ======================================================================
    // Compare circuits and event flags
    // ======================================================================
    assign any_compare = ~cc_mode_q[0] | ~cc_mode_q[1];

    always_comb begin
        flags_d = flags_q;
        match_d = 2'b00;
        for (int i = 0; i < 2; i++) begin
            cc_cmp_d[i] = cc_cmp_q[i];
            if (buf_load(cc_buf_q[i], hit_zero, hit_limit, ~running)) begin
                cc_cmp_d[i] = cc_val_q[i];
            end
        end
        // Clearing comes first so that an event in the same cycle survives.
        if (WR_STB && (ADDR == `UDT_REG_EVFLAG)) begin
            flags_d = flags_q & ~ev_bits(WDATA);
        end
        for (int i = 0; i < 2; i++) begin
            if (!cc_mode_q[i] && running && tick && (count_d == cc_cmp_q[i])) begin
                match_d[i] = 1'b1;
                flags_d[i] = 1'b1;
            end
        end
        if (any_compare && hit_limit) begin
            flags_d[`UDT_EV_LIMIT] = 1'b1;
        end
        if (any_compare && hit_zero) begin
            flags_d[`UDT_EV_ZERO] = 1'b1;
        end
        irq_d = |(flags_d & enables_q);
    end

    // ======================================================================
    // Register port
    // ======================================================================
    always_comb begin
        enable_d  = enable_q;
        oneshot_d = oneshot_q;
        dir_sel_d = dir_sel_q;
        limit_d   = limit_q;
        enables_d = enables_q;
        cc_mode_d = cc_mode_q;
        for (int i = 0; i < 2; i++) begin
            cc_buf_d[i] = cc_buf_q[i];
            cc_val_d[i] = cc_val_q[i];
        end
        if (WR_STB) begin
            unique case (ADDR)
                `UDT_REG_CONTROL: begin
                    enable_d  = WDATA[`UDT_CTL_ENABLE];
                    oneshot_d = WDATA[`UDT_CTL_ONESHOT];
                    dir_sel_d = udt_dir_t'(WDATA[`UDT_CTL_DIR_HI:`UDT_CTL_DIR_LO]);
                end
                `UDT_REG_LIMIT: begin
                    if (!lbusy_q) begin
                        limit_d = WDATA;
                    end
                end
                `UDT_REG_EVENABLE: enables_d = ev_bits(WDATA);
                `UDT_REG_CCCTL0: begin
                    cc_mode_d[0] = WDATA[`UDT_CC_MODE];
                    cc_buf_d[0]  = udt_buf_t'(WDATA[`UDT_CC_BUF_HI:`UDT_CC_BUF_LO]);
                end
                `UDT_REG_CCCTL1: begin
                    cc_mode_d[1] = WDATA[`UDT_CC_MODE];
                    cc_buf_d[1]  = udt_buf_t'(WDATA[`UDT_CC_BUF_HI:`UDT_CC_BUF_LO]);
                end
                `UDT_REG_CCVAL0: cc_val_d[0] = WDATA;
                `UDT_REG_CCVAL1: cc_val_d[1] = WDATA;
                default: ;
            endcase
        end
        rdata_d = 16'h0000;
        if (RD_STB) begin
            unique case (ADDR)
                `UDT_REG_CONTROL: rdata_d = {7'h00, lbusy_q, 2'h0, dir_sel_q, oneshot_q,
                                             run_q, 1'b0, enable_q};
                `UDT_REG_LIMIT:    rdata_d = limit_q;
                // The count changes with the count clock; software must confirm it.
                `UDT_REG_COUNT:    rdata_d = count_q;
                `UDT_REG_STATE:    rdata_d = {14'h0000, up_now, running};
                `UDT_REG_EVFLAG:   rdata_d = ev_word(flags_q);
                `UDT_REG_EVENABLE: rdata_d = ev_word(enables_q);
                `UDT_REG_CCCTL0:   rdata_d = {12'h000, cc_buf_q[0], cc_mode_q[0]};
                `UDT_REG_CCCTL1:   rdata_d = {12'h000, cc_buf_q[1], cc_mode_q[1]};
                `UDT_REG_CCVAL0:   rdata_d = cc_val_q[0];
                `UDT_REG_CCVAL1:   rdata_d = cc_val_q[1];
                default:           rdata_d = 16'h0000;
            endcase
        end
    end

    // ======================================================================
    // Registers
    // ======================================================================
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            enable_q    <= 1'b0;
            run_q       <= 1'b0;
            oneshot_q   <= 1'b0;
            dir_sel_q   <= UDT_DIR_UP;
            limit_q     <= `UDT_RST_LIMIT;
            limit_act_q <= `UDT_RST_LIMIT;
            lbusy_q     <= 1'b0;
            count_q     <= `UDT_RST_ZERO16;
            phase_up_q  <= 1'b1;
            flags_q     <= 6'h00;
            enables_q   <= 6'h00;
            cc_mode_q   <= 2'b00;
            cclk_q      <= 1'b0;
            RDATA       <= 16'h0000;
            IRQ         <= 1'b0;
            CC_MATCH    <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                cc_buf_q[i] <= UDT_BUF_NOW;
                cc_val_q[i] <= `UDT_RST_ZERO16;
                cc_cmp_q[i] <= `UDT_RST_ZERO16;
            end
        end else begin
            enable_q    <= enable_d;
            run_q       <= run_d;
            oneshot_q   <= oneshot_d;
            dir_sel_q   <= dir_sel_d;
            limit_q     <= limit_d;
            limit_act_q <= limit_act_d;
            lbusy_q     <= lbusy_d;
            count_q     <= count_d;
            phase_up_q  <= phase_up_d;
            flags_q     <= flags_d;
            enables_q   <= enables_d;
            cc_mode_q   <= cc_mode_d;
            cclk_q      <= cclk_d;
            RDATA       <= rdata_d;
            IRQ         <= irq_d;
            CC_MATCH    <= match_d;
            for (int i = 0; i < 2; i++) begin
                cc_buf_q[i] <= cc_buf_d[i];
                cc_val_q[i] <= cc_val_d[i];
                cc_cmp_q[i] <= cc_cmp_d[i];
            end
        end
    end

endmodule

`default_nettype wire

// ### design/udt_regs.svh
// Register offsets, field positions and reset values of the up/down timer core.
`ifndef UDT_REGS_SVH
`define UDT_REGS_SVH

// ==========================================================================
// Register indices on the plain register port
// ==========================================================================
`define UDT_ADDR_W            4
`define UDT_REG_CONTROL       4'h0
`define UDT_REG_LIMIT         4'h1
`define UDT_REG_COUNT         4'h2
`define UDT_REG_STATE         4'h3
`define UDT_REG_EVFLAG        4'h4
`define UDT_REG_EVENABLE      4'h5
`define UDT_REG_CCCTL0        4'h6
`define UDT_REG_CCCTL1        4'h7
`define UDT_REG_CCVAL0        4'h8
`define UDT_REG_CCVAL1        4'h9

// ==========================================================================
// Field positions
// ==========================================================================
`define UDT_CTL_ENABLE        0
`define UDT_CTL_PRESET        1
`define UDT_CTL_RUN           2
`define UDT_CTL_ONESHOT       3
`define UDT_CTL_DIR_LO        4
`define UDT_CTL_DIR_HI        5
`define UDT_CTL_BUSY          8
`define UDT_ST_RUNNING        0
`define UDT_ST_UP             1
`define UDT_EV_CC0            0
`define UDT_EV_CC1            1
`define UDT_EV_LIMIT          4
`define UDT_EV_ZERO           5
`define UDT_CC_MODE           0
`define UDT_CC_BUF_LO         1
`define UDT_CC_BUF_HI         3

// ==========================================================================
// Reset values and constants
// ==========================================================================
`define UDT_RST_LIMIT         16'hffff
`define UDT_RST_ZERO16        16'h0000
`define UDT_EV_MASK           16'h0033

`endif

// ### design/udt_pkg.sv
// Types shared by the up/down timer core.
package udt_pkg;

    // ======================================================================
    // Counting direction selection
    // ======================================================================
    typedef enum logic [1:0] {
        UDT_DIR_UP     = 2'h0,
        UDT_DIR_DOWN   = 2'h1,
        UDT_DIR_UPDOWN = 2'h2,
        UDT_DIR_RSVD   = 2'h3
    } udt_dir_t;

    // ======================================================================
    // Compare buffer load timing
    // ======================================================================
    typedef enum logic [2:0] {
        UDT_BUF_NOW      = 3'h0,
        UDT_BUF_AT_ZERO  = 3'h1,
        UDT_BUF_AT_LIMIT = 3'h2,
        UDT_BUF_AT_BOTH  = 3'h3,
        UDT_BUF_AT_STOP  = 3'h4
    } udt_buf_t;

endpackage

// ### sim/udt_core_props.sv
// Port-level checker for the up/down timer core.
`include "udt_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module udt_core_props (
    input wire logic                   MCLK,
    input wire logic                   RESET_N,
    input wire logic                   COUNT_CLOCK,
    input wire logic [`UDT_ADDR_W-1:0] ADDR,
    input wire logic [15:0]            WDATA,
    input wire logic                   WR_STB,
    input wire logic                   RD_STB,
    input wire logic [15:0]            RDATA,
    input wire logic                   IRQ,
    input wire logic [1:0]             CC_MATCH
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);

    // ======================================================================
    // Register port
    // ======================================================================
    read_idle_zero_a: assert property (!$past(RD_STB) |-> RDATA == 16'h0000)
        else $error("read data not zero outside a read answer");
    ctl_fields_a: assert property (RD_STB && ADDR == `UDT_REG_CONTROL |=>
        (RDATA & 16'hfec2) == 16'h0000)
        else $error("control read shows preset or reserved bits");
    state_fields_a: assert property (RD_STB && ADDR == `UDT_REG_STATE |=>
        RDATA[15:2] == 14'h0000)
        else $error("state read shows reserved bits");
    flag_fields_a: assert property (RD_STB && ADDR == `UDT_REG_EVFLAG |=>
        (RDATA & ~`UDT_EV_MASK) == 16'h0000)
        else $error("flag read shows unused bits");

    // ======================================================================
    // Interrupt and match outputs
    // ======================================================================
    irq_mask_a: assert property (WR_STB && ADDR == `UDT_REG_EVENABLE && WDATA == 16'h0000
        |=> ##1 !IRQ)
        else $error("request stays up with all enables clear");
    irq_cause_a: assert property ($rose(IRQ) |-> $past(COUNT_CLOCK) || $past(WR_STB, 2))
        else $error("request rose without a counting edge or an enable write");
    match_cause_a: assert property (CC_MATCH != 2'b00 |->
        $past(COUNT_CLOCK) && !$past(COUNT_CLOCK, 2))
        else $error("match pulse without a counting edge");
    match_single_a: assert property (CC_MATCH[0] || CC_MATCH[1] |=> CC_MATCH == 2'b00)
        else $error("match pulse longer than one cycle");

    match_seen_c: cover property (CC_MATCH[0]);
    irq_seen_c: cover property ($rose(IRQ));
    count_read_c: cover property (RD_STB && ADDR == `UDT_REG_COUNT);
endmodule

`default_nettype wire

// ### sim/udt_core_bench.sv
// Self-checking bench for the up/down timer core.
`include "udt_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module udt_core_bench;
    import udt_pkg::*;
    typedef logic [15:0] udt_seq_t [8];

    logic                   MCLK;
    logic                   RESET_N;
    logic                   COUNT_CLOCK;
    logic [`UDT_ADDR_W-1:0] ADDR;
    logic [15:0]            WDATA;
    logic                   WR_STB;
    logic                   RD_STB;
    logic [15:0]            RDATA;
    logic                   IRQ;
    logic [1:0]             CC_MATCH;
    logic [15:0]            rv;
    logic [1:0]             mt;
    int                     num_errors;
    int                     checks;

    udt_core dut (.MCLK(MCLK), .RESET_N(RESET_N), .COUNT_CLOCK(COUNT_CLOCK), .ADDR(ADDR),
                  .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
                  .IRQ(IRQ), .CC_MATCH(CC_MATCH));

    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end

    // ======================================================================
    // Access and compare tasks
    // ======================================================================
    task automatic close_out;
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge MCLK);
        WR_STB <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR_STB <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample at that edge.
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge MCLK);
        RD_STB <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD_STB <= 1'b0;
        @(posedge MCLK);
        v = RDATA;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    // One count clock period: high one cycle, then low, match sampled after the edge.
    task automatic step(input logic [15:0] exp);
        @(posedge MCLK);
        COUNT_CLOCK <= 1'b1;
        @(posedge MCLK);
        COUNT_CLOCK <= 1'b0;
        @(posedge MCLK);
        mt = CC_MATCH;
        rdc(`UDT_REG_COUNT, exp);
    endtask

    task automatic seq(input udt_seq_t e, input int n);
        for (int i = 0; i < n; i++) begin
            step(e[i]);
        end
    endtask

    initial begin
        #100us;
        num_errors++;
        close_out();
    end

    // ======================================================================
    // Tests
    // ======================================================================
    initial begin
        RESET_N = 1'b0;
        COUNT_CLOCK = 1'b0;
        ADDR = '0;
        WDATA = 16'h0000;
        WR_STB = 1'b0;
        RD_STB = 1'b0;
        repeat (4) @(posedge MCLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge MCLK);
        rdc(`UDT_REG_LIMIT, `UDT_RST_LIMIT);
        rdc(`UDT_REG_CONTROL, 16'h0000);
        rdc(4'hf, 16'h0000);
        wr(`UDT_REG_LIMIT, 16'h0002);
        wr(`UDT_REG_CCVAL0, 16'h0001);
        wr(`UDT_REG_CCVAL1, 16'h0009);
        wr(`UDT_REG_EVENABLE, 16'h0010);
        wr(`UDT_REG_CONTROL, 16'h0007);
        rdc(`UDT_REG_STATE, 16'h0003);
        step(16'h0001);
        chk({14'h0000, mt}, 16'h0001);
        step(16'h0002);
        step(16'h0000);
        chk({14'h0000, mt}, 16'h0000);
        rdc(`UDT_REG_EVFLAG, 16'h0031);
        chk({15'h0000, IRQ}, 16'h0001);
        wr(`UDT_REG_EVFLAG, 16'h0031);
        rdc(`UDT_REG_EVFLAG, 16'h0000);
        chk({15'h0000, IRQ}, 16'h0000);
        wr(`UDT_REG_EVENABLE, 16'h0020);
        seq('{16'h0001, 16'h0002, '0, '0, '0, '0, '0, '0}, 2);
        chk({15'h0000, IRQ}, 16'h0000);
        step(16'h0000);
        chk({15'h0000, IRQ}, 16'h0001);
        wr(`UDT_REG_EVENABLE, 16'h0000);
        step(16'h0001);
        wr(`UDT_REG_CONTROL, 16'h0001);
        seq('{16'h0001, 16'h0001, '0, '0, '0, '0, '0, '0}, 2);
        rd(`UDT_REG_STATE, rv);
        chk(rv & 16'h0001, 16'h0000);
        wr(`UDT_REG_LIMIT, 16'h0005);
        wr(`UDT_REG_CONTROL, 16'h0007);
        seq('{16'h0001, 16'h0002, 16'h0003, '0, '0, '0, '0, '0}, 3);
        rd(`UDT_REG_CONTROL, rv);
        chk(rv & 16'h0100, 16'h0000);
        wr(`UDT_REG_LIMIT, 16'h0002);
        seq('{16'h0000, 16'h0001, '0, '0, '0, '0, '0, '0}, 2);
        wr(`UDT_REG_LIMIT, 16'h0001);
        wr(`UDT_REG_CONTROL, 16'h000f);
        seq('{16'h0001, 16'h0000, 16'h0000, '0, '0, '0, '0, '0}, 3);
        wr(`UDT_REG_LIMIT, 16'h0002);
        wr(`UDT_REG_CONTROL, 16'h0017);
        rdc(`UDT_REG_COUNT, 16'h0002);
        rdc(`UDT_REG_STATE, 16'h0001);
        step(16'h0001);
        wr(`UDT_REG_LIMIT, 16'h0003);
        rd(`UDT_REG_CONTROL, rv);
        chk(rv & 16'h0100, 16'h0100);
        wr(`UDT_REG_LIMIT, 16'h0005);
        seq('{16'h0000, 16'h0003, 16'h0002, '0, '0, '0, '0, '0}, 3);
        rdc(`UDT_REG_LIMIT, 16'h0003);
        wr(`UDT_REG_CONTROL, 16'h001f);
        seq('{16'h0002, 16'h0001, 16'h0000, 16'h0003, 16'h0003, '0, '0, '0}, 5);
        wr(`UDT_REG_LIMIT, 16'h0002);
        wr(`UDT_REG_CONTROL, 16'h0027);
        seq('{16'h0001, 16'h0002, 16'h0001, '0, '0, '0, '0, '0}, 3);
        rdc(`UDT_REG_STATE, 16'h0001);
        wr(`UDT_REG_LIMIT, 16'h0003);
        seq('{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0002, '0, '0, '0}, 5);
        wr(`UDT_REG_CONTROL, 16'h002f);
        seq('{16'h0001, 16'h0002, 16'h0003, 16'h0002,
              16'h0001, 16'h0000, 16'h0000, '0}, 7);
        rd(`UDT_REG_STATE, rv);
        chk(rv & 16'h0001, 16'h0000);
        wr(`UDT_REG_CCCTL1, 16'h0001);
        wr(`UDT_REG_CCVAL1, 16'h0002);
        wr(`UDT_REG_CCCTL0, 16'h0002);
        wr(`UDT_REG_CONTROL, 16'h0007);
        wr(`UDT_REG_CCVAL0, 16'h0003);
        step(16'h0001);
        chk({14'h0000, mt}, 16'h0001);
        step(16'h0002);
        chk({14'h0000, mt}, 16'h0000);
        step(16'h0003);
        chk({14'h0000, mt}, 16'h0000);
        seq('{16'h0000, 16'h0001, 16'h0002, '0, '0, '0, '0, '0}, 3);
        step(16'h0003);
        chk({14'h0000, mt}, 16'h0001);
        rd(`UDT_REG_EVFLAG, rv);
        chk(rv & 16'h0002, 16'h0000);
        rdc(`UDT_REG_CCCTL0, 16'h0002);
        rdc(`UDT_REG_CCCTL1, 16'h0001);
        close_out();
    end
endmodule

bind udt_core udt_core_props chk_i (.MCLK(MCLK), .RESET_N(RESET_N), .COUNT_CLOCK(COUNT_CLOCK),
    .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
    .IRQ(IRQ), .CC_MATCH(CC_MATCH));

`default_nettype wire
